// ---- lsw_consts.vh ----
// constants for the loop status word reporting block
`ifndef LSW_CONSTS_VH
`define LSW_CONSTS_VH
`define LSW_STATUS_OFFSET 4'h8
`define LSW_DECERR_OFFSET 4'h7
`define LSW_BIT_SAVE_DONE 15
`define LSW_BIT_SENSOR 14
`define LSW_BIT_CUR_OVF 13
`define LSW_BIT_FATAL 12
`define LSW_BIT_STANDBY 11
`define LSW_BIT_PID_CALC 10
`define LSW_BIT_SET_ERR 9
`define LSW_BIT_STOP 8
`define LSW_BIT_CTRL_OUT 4
`define LSW_BIT_AUTOTUNE 3
`define LSW_BIT_BURNOUT 2
`define LSW_DEC1_MSB 15
`define LSW_DEC1_LSB 12
`define LSW_DEC2_MSB 11
`define LSW_DEC2_LSB 8
`define LSW_ERR1_MSB 7
`define LSW_ERR1_LSB 4
`define LSW_ERR2_MSB 3
`define LSW_ERR2_LSB 0
`define LSW_CUR_LIMIT_DA 12'h226
`define LSW_WORD_RESET 16'h0000
`define LSW_STATUS_RESET 16'h0800
`endif

// ---- lsw_sync2.v ----
// two-flop synchroniser for a bus of pin-level inputs
`timescale 1ns/10ps
module lsw_sync2
#(
   parameter WIDTH = 1
)
(
   input wire clock,
   input wire arst_n,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] stage_reg;

   // first stage feeds only the second
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage_reg <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end
      else
      begin
         stage_reg <= din;
         dout <= stage_reg;
      end
   end
endmodule

// ---- lsw_rise.v ----
// rising edge detector on a synchronised level
`timescale 1ns/10ps
module lsw_rise
(
   input wire clock,
   input wire arst_n,
   input wire level,
   output wire rise
);

   reg last_reg;

   // previous value, reset low so a level high at reset counts once
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         last_reg <= 1'b0;
      else
         last_reg <= level;
   end

   assign rise = level & ~last_reg;
endmodule

// ---- lsw_status.v ----
// loop status and decimal/setting-error input words for the host
`timescale 1ns/10ps
`include "lsw_consts.vh"
// Behaviour
// - decimal field: 0 none, 1 one digit
// - setting error indices, loop1 upper nibble
// - save-done set when nonvolatile save finishes
// - save request clears save-done; zero at power-up
// - sensor fault: absent, broken or out-of-range
// - current overflow above 55.0 A
// - fatal on compensator failure or watchdog
// - standby until first refresh after restart
// - recalculated flag set on new PID constants
// - recalculated set means constants not yet sent
// - change request clears flag, reloads constants
// - setting error on any invalid host setting
// - stop flag set while regulation halted
// - bits 5 to 7 read zero
// - output flag mirrors control output
// - autotune flag high while autotune runs
// - burnout when current reaches threshold
module lsw_status
(
   // clock, reset and the host refresh strobe
   input wire clock,
   input wire arst_n,
   input wire ioRefresh,
   // host output word request levels, save and autotune completion, mode levels
   input wire saveRequest,
   input wire saveFinished,
   input wire changeConstRequest,
   input wire constantsUpdated,
   input wire stopRequest,
   input wire programMode,
   input wire configSwitch1,
   // field levels from the loop hardware
   input wire sensorAbsent,
   input wire sensorBroken,
   input wire sensorOutOfRange,
   input wire [11:0] heaterCurrent,
   input wire [11:0] burnoutThreshold,
   input wire coldJunctionFault,
   input wire host_watchdog_timeout,
   input wire controlOutput,
   input wire autotune_active,
   input wire settingInvalid,
   // loop logic values, already on this clock
   input wire [3:0] errIndexLoop1,
   input wire [3:0] errIndexLoop2,
   input wire decimalLoop1,
   input wire decimalLoop2,
   // host read port and snapshot outputs
   input wire [3:0] wordSelect,
   output reg [15:0] readData,
   output reg [15:0] statusWord,
   output reg [15:0] decErrWord,
   output reg regulationHalted,
   output reg reloadConstants
);

   localparam NPIN = 17;

   // raw and synchronised field inputs
   wire [NPIN-1:0] pinRaw;
   wire [NPIN-1:0] pinSync;
   wire [11:0] curSync;
   wire [11:0] thrSync;
   wire saveReqS, saveFinS, chgReqS, constUpdS, stopReqS, progS, sw1S;
   wire absentS, brokenS, rangeS, cjcS, wdogS, outS, tuneS, setInvS;
   wire dec1S, dec2S;

   // edge pulses, one cycle wide
   wire saveReqRise, saveFinRise, chgReqRise, constUpdRise;

   // combined level flags
   wire sensorFault;
   wire curOverflow;
   wire fatalFault;
   wire burnoutHit;

   // flag state held between refreshes
   reg saveDone_reg;
   reg pidCalc_reg;
   reg standby_reg;
   reg stopLatch_reg;
   reg [15:0] statusNext;
   reg [15:0] decErrNext;

   // magnitude test shared by the overflow and burnout flags
   function lsw_cmp;
      input [11:0] value;
      input [11:0] limit;
      input orEqual;
   begin
      if (orEqual)
         lsw_cmp = (value >= limit);
      else
         lsw_cmp = (value > limit);
   end
   endfunction

   // offset decode for the host read port; holes read zero
   function [15:0] lsw_pick;
      input [3:0] sel;
      input [15:0] status;
      input [15:0] decErr;
   begin
      case (sel)
         `LSW_STATUS_OFFSET:
            lsw_pick = status;
         `LSW_DECERR_OFFSET:
            lsw_pick = decErr;
         default:
            lsw_pick = `LSW_WORD_RESET;
      endcase
   end
   endfunction

   // all host and field levels come from outside the clock domain
   assign pinRaw = {saveRequest, saveFinished, changeConstRequest,
      constantsUpdated, stopRequest, programMode, configSwitch1,
      sensorAbsent, sensorBroken, sensorOutOfRange, coldJunctionFault,
      host_watchdog_timeout, controlOutput, autotune_active,
      settingInvalid, decimalLoop1, decimalLoop2};

   lsw_sync2 #(.WIDTH(NPIN)) uSyncPins
   (
      .clock(clock),
      .arst_n(arst_n),
      .din(pinRaw),
      .dout(pinSync)
   );

   // multi-bit values may tear for one cycle; a refresh in that cycle snapshots the torn value
   lsw_sync2 #(.WIDTH(24)) uSyncCur
   (
      .clock(clock),
      .arst_n(arst_n),
      .din({heaterCurrent, burnoutThreshold}),
      .dout({curSync, thrSync})
   );

   // split the synchronised bus back into names
   assign {saveReqS, saveFinS, chgReqS, constUpdS, stopReqS, progS, sw1S,
      absentS, brokenS, rangeS, cjcS, wdogS, outS, tuneS, setInvS,
      dec1S, dec2S} = pinSync;

   // level flags from the synchronised field inputs
   assign sensorFault = absentS | brokenS | rangeS;
   assign curOverflow = lsw_cmp(curSync, `LSW_CUR_LIMIT_DA, 1'b0);
   assign fatalFault = cjcS | wdogS;
   assign burnoutHit = lsw_cmp(curSync, thrSync, 1'b1);

   // host save bit edge
   lsw_rise uRiseSave
   (
      .clock(clock),
      .arst_n(arst_n),
      .level(saveReqS),
      .rise(saveReqRise)
   );

   // nonvolatile save finished edge
   lsw_rise uRiseFin
   (
      .clock(clock),
      .arst_n(arst_n),
      .level(saveFinS),
      .rise(saveFinRise)
   );

   // host change-constants bit edge
   lsw_rise uRiseChg
   (
      .clock(clock),
      .arst_n(arst_n),
      .level(chgReqS),
      .rise(chgReqRise)
   );

   // autotune produced new constants edge
   lsw_rise uRiseUpd
   (
      .clock(clock),
      .arst_n(arst_n),
      .level(constUpdS),
      .rise(constUpdRise)
   );

   // save-done: finish sets, request clears; set wins a tie
   // a finish on the edge of a new request still reports done
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         saveDone_reg <= 1'b0;
      else if (saveFinRise)
         saveDone_reg <= 1'b1;
      else if (saveReqRise)
         saveDone_reg <= 1'b0;
   end

   // recalculated constants: high means host copy not yet sent
   // the reload pulse below is what hands the host copy over
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         pidCalc_reg <= 1'b0;
      else if (constUpdRise)
         pidCalc_reg <= 1'b1;
      else if (chgReqRise)
         pidCalc_reg <= 1'b0;
   end

   // reload pulse toward the loop when the host asks for a change
   // one cycle late so it lines up with the cleared flag
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         reloadConstants <= 1'b0;
      else
         reloadConstants <= chgReqRise;
   end

   // standby from reset until the first refresh
   // a restart puts the flag back until the host refreshes again
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         standby_reg <= 1'b1;
      else if (ioRefresh)
         standby_reg <= 1'b0;
   end

   // stop request holds its last value in program mode with switch off
   // hazard: a stop bit toggled while frozen is lost, not queued
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         stopLatch_reg <= 1'b0;
      else if (!(progS && !sw1S))
         stopLatch_reg <= stopReqS;
   end

   // halted flag is a registered copy so bit 8 never glitches
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         regulationHalted <= 1'b0;
      else
         regulationHalted <= stopLatch_reg;
   end

   // assemble the live words
   always @*
   begin
      // loop 1 flag word; reserved bits 5 to 7 stay zero
      statusNext = `LSW_WORD_RESET;
      statusNext[`LSW_BIT_SAVE_DONE] = saveDone_reg;
      statusNext[`LSW_BIT_SENSOR] = sensorFault;
      statusNext[`LSW_BIT_CUR_OVF] = curOverflow;
      statusNext[`LSW_BIT_FATAL] = fatalFault;
      statusNext[`LSW_BIT_STANDBY] = standby_reg;
      statusNext[`LSW_BIT_PID_CALC] = pidCalc_reg;
      statusNext[`LSW_BIT_SET_ERR] = setInvS;
      statusNext[`LSW_BIT_STOP] = regulationHalted;
      statusNext[`LSW_BIT_CTRL_OUT] = outS;
      statusNext[`LSW_BIT_AUTOTUNE] = tuneS;
      statusNext[`LSW_BIT_BURNOUT] = burnoutHit;
      // decimal places and setting error numbers
      decErrNext = `LSW_WORD_RESET;
      decErrNext[`LSW_DEC1_MSB:`LSW_DEC1_LSB] = {3'h0, dec1S};
      decErrNext[`LSW_DEC2_MSB:`LSW_DEC2_LSB] = {3'h0, dec2S};
      decErrNext[`LSW_ERR1_MSB:`LSW_ERR1_LSB] = errIndexLoop1;
      decErrNext[`LSW_ERR2_MSB:`LSW_ERR2_LSB] = errIndexLoop2;
   end

   // snapshot once per refresh so host sees a coherent pair
   // standby shows in the snapshot taken while still waiting
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         statusWord <= `LSW_STATUS_RESET;
         decErrWord <= `LSW_WORD_RESET;
      end
      else if (ioRefresh)
      begin
         statusWord <= statusNext;
         decErrWord <= decErrNext;
      end
   end

   // word read by offset; unmapped offsets read zero
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         readData <= `LSW_WORD_RESET;
      else
         readData <= lsw_pick(wordSelect, statusWord, decErrWord);
   end
endmodule

// ---- lsw_host.sv ----
// host model: output control word and refresh pulse
`timescale 1ns/10ps
module lsw_host
(
   input wire clock,
   input wire [15:0] ctrlWord,
   input wire kick,
   output wire saveRequest,
   output wire changeConstRequest,
   output wire stopRequest,
   output reg ioRefresh
);
   // request bits come straight off the host word
   assign saveRequest = ctrlWord[15];
   assign changeConstRequest = ctrlWord[13];
   assign stopRequest = ctrlWord[6];
   // one-cycle refresh, moved off the sampling edge
   initial ioRefresh = 1'b0;
   always @(negedge clock)
      ioRefresh <= kick;
endmodule

// ---- lsw_status_sva.sv ----
// assertions on the status block ports
`timescale 1ns/10ps
module lsw_status_sva
(
   input wire clock,
   input wire arst_n,
   input wire ioRefresh,
   input wire stopRequest,
   input wire programMode,
   input wire configSwitch1,
   input wire [11:0] heaterCurrent,
   input wire [11:0] burnoutThreshold,
   input wire [3:0] errIndexLoop1,
   input wire [3:0] errIndexLoop2,
   input wire decimalLoop1,
   input wire [3:0] wordSelect,
   input wire [15:0] readData,
   input wire [15:0] statusWord,
   input wire [15:0] decErrWord,
   input wire regulationHalted
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // inputs held long enough to cross the synchronisers
   sequence calm;
      ($stable(heaterCurrent) && $stable(burnoutThreshold)
         && $stable(decimalLoop1))[*4] ##0 ioRefresh;
   endsequence
   sequence stopCalm;
      ($stable(stopRequest) && $stable(programMode)
         && $stable(configSwitch1))[*6];
   endsequence
   a_reserved_zero: assert property (statusWord[7:5] == 3'h0)
      else $error("reserved bits set");
   a_snapshot_hold: assert property (!ioRefresh |=>
      $stable(statusWord) && $stable(decErrWord)) else $error("no hold");
   a_ct_overflow: assert property (calm |=>
      statusWord[13] == ($past(heaterCurrent) > 12'h226))
      else $error("overflow bit");
   a_burnout_flag: assert property (calm |=> statusWord[2] ==
      ($past(heaterCurrent) >= $past(burnoutThreshold)))
      else $error("burnout bit");
   a_error_index: assert property (ioRefresh |=> decErrWord[7:0] ==
      {$past(errIndexLoop1), $past(errIndexLoop2)}) else $error("index");
   a_decimal_field: assert property (calm |=>
      decErrWord[15:12] == {3'h0, $past(decimalLoop1)})
      else $error("decimal field");
   a_stop_level: assert property (stopCalm ##0
      !(programMode && !configSwitch1) |-> regulationHalted == stopRequest)
      else $error("halt level");
   a_unmapped_zero: assert property (!(wordSelect inside {4'h7, 4'h8})
      |=> readData == 16'h0000) else $error("unmapped read");
endmodule
bind lsw_status lsw_status_sva chk (.clock, .arst_n, .ioRefresh,
   .stopRequest, .programMode, .configSwitch1, .heaterCurrent,
   .burnoutThreshold, .errIndexLoop1, .errIndexLoop2, .decimalLoop1,
   .wordSelect, .readData, .statusWord, .decErrWord, .regulationHalted);

// ---- loop_status_word_reporting_test.sv ----
// self-checking bench for the loop status block
`timescale 1ns/10ps
module loop_status_word_reporting_test;
   reg clock, arst_n, kick, fin, upd, pm, sw1, sa, sb, so, cj, wd;
   reg co, tu, si, d1, d2, pS, pF, pC, pU;
   reg [15:0] ctrl, es, ed;
   reg [11:0] cur, thr;
   reg [3:0] e1, e2, ws;
   wire ioRefresh, saveRequest, changeConstRequest, stopRequest;
   wire regulationHalted, reloadConstants;
   wire [15:0] readData, statusWord, decErrWord;
   integer n_errors = 0, num_checks = 0, i, sd = 0, pid = 0, stby = 1;
   integer halt = 0, nRel = 0, eRel = 0;
   lsw_host host (.clock, .ctrlWord(ctrl), .kick, .saveRequest,
      .changeConstRequest, .stopRequest, .ioRefresh);
   lsw_status dut (.clock, .arst_n, .ioRefresh, .saveRequest,
      .saveFinished(fin), .changeConstRequest, .constantsUpdated(upd),
      .stopRequest, .programMode(pm), .configSwitch1(sw1),
      .sensorAbsent(sa), .sensorBroken(sb), .sensorOutOfRange(so),
      .heaterCurrent(cur), .burnoutThreshold(thr),
      .coldJunctionFault(cj), .host_watchdog_timeout(wd),
      .controlOutput(co), .autotune_active(tu), .settingInvalid(si),
      .errIndexLoop1(e1), .errIndexLoop2(e2), .decimalLoop1(d1),
      .decimalLoop2(d2), .wordSelect(ws), .readData, .statusWord,
      .decErrWord, .regulationHalted, .reloadConstants);
   // clock and reload pulse counter
   initial
   begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   // counted on the falling edge, where the pulse has settled
   always @(negedge clock)
      if (reloadConstants === 1'b1) nRel = nRel + 1;
   task chk(input [15:0] got, input [15:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task close_out;
   begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   // watchdog well past the expected run of about 35 us
   initial
   begin
      #400000;
      n_errors = n_errors + 1;
      close_out;
   end
   // random refresh rounds against the integer model
   initial
   begin
      {arst_n, kick, fin, upd, pm, sw1, sa, sb, so, cj, wd} = 0;
      {co, tu, si, d1, d2, pS, pF, pC, pU} = 0;
      {ctrl, cur, thr, e1, e2, ws} = 0;
      i = $urandom(37);
      repeat (3) @(negedge clock);
      arst_n = 1;
      @(negedge clock);
      chk(statusWord, 16'h0800);
      chk(decErrWord, 16'h0000);
      $display("reset test done");
      for (i = 0; i < 40; i = i + 1)
      begin
         // mode change settles apart from the stop bit
         {pm, sw1} = $urandom;
         repeat (6) @(negedge clock);
         {fin, upd, sa, sb, so, cj, wd, co, tu, si, d1, d2} = $urandom;
         {e1, e2} = $urandom;
         ctrl = $urandom & 16'ha040;
         cur = i[0] ? 12'h225 + $urandom % 3 : $urandom;
         thr = cur + $urandom % 3 - 1;
         if (fin && !pF) sd = 1; else if (ctrl[15] && !pS) sd = 0;
         if (upd && !pU) pid = 1; else if (ctrl[13] && !pC) pid = 0;
         if (ctrl[13] && !pC) eRel = eRel + 1;
         if (!(pm && !sw1)) halt = ctrl[6];
         {pS, pF, pC, pU} = {ctrl[15], fin, ctrl[13], upd};
         es = {sd[0], sa | sb | so, cur > 12'h226, cj | wd, stby[0],
            pid[0], si, halt[0], 3'h0, co, tu, cur >= thr, 2'h0};
         ed = {3'h0, d1, 3'h0, d2, e1, e2};
         stby = 0;
         repeat (6) @(negedge clock);
         kick <= 1'b1;
         @(negedge clock);
         kick <= 1'b0;
         repeat (2) @(negedge clock);
         chk(statusWord, es);
         chk(decErrWord, ed);
         ws = 4'h8;
         @(negedge clock);
         chk(readData, es);
         ws = $urandom;
         @(negedge clock);
         chk(readData, ws == 8 ? es : ws == 7 ? ed : 16'h0);
      end
      chk(nRel[15:0], eRel[15:0]);
      $display("random test done");
      close_out;
   end
endmodule
